// >>> verilog/ace_axle_count_evaluator.sv
// Axle count evaluator: sensor qualification, direction, dual counter,
// fail-safe latches, key reset sequence and an Avalon-MM register slave.
// Assumes sensor, fault and key pins are asynchronous and one 40 MHz clock.
//
// Behaviour
// - Sensor pulses shorter than the minimum flange duration are discarded as noise.
// - Outside fail-safe, each qualified axle gives a clean one-cycle up or down count pulse.
// - Entering axles raise extended redundant direct release outputs, independent of counting.
// - Up or down is decided by which sensor system is crossed first.
// - An entering axle increments both counter channels together.
// - A leaving axle decrements both counter channels together.
// - Release triggers on the configured entering axle or pulse count.
// - Short, open or off-rail sensor forces breakdown plus occupied.
// - Off-rail beyond one millimetre, flagged by the front end, enters fail-safe.
// - One or more axles held energises both occupied outputs.
// - One or more axles held drops both vacancy outputs.
// - Counting out more axles than in is a minus-axle error.
// - Minus-axle error blocks counting and holds the section occupied.
// - Only the reset key clears minus-axle lockout, not further counting.
// - Reset clears both counters, counts one axle in and out, restores vacant.
// - Both counter channels must always agree; divergence is an internal fault.
// - Vacancy outputs are energised only at zero count and unoccupied.
module ace_axle_count_evaluator
	import ace_pkg::*;
#(
	parameter int unsigned MIN_PULSE_CYCLES = ace_pkg::MIN_PULSE_CYC,
	parameter int unsigned KEY_HOLD_CYCLES = ace_pkg::KEY_HOLD_CYC,
	parameter int unsigned RELEASE_CYCLES = ace_pkg::RELEASE_CYC
) (
	// Clock and reset
	input wire logic REF_CLK_I,
	input wire logic RST_N_I,
	// Avalon-MM slave
	input wire logic [2:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	// Double wheel sensor and its fault lines
	input wire logic SENSOR_SYSTEM_ONE_I,
	input wire logic SENSOR_SYSTEM_TWO_I,
	input wire ace_pkg::ace_fault_t SENSOR_FAULT_I,
	// Reset key
	input wire logic COUNTER_RESET_KEY_I,
	// Count pulses and direct release
	output logic COUNT_PULSE_OUTPUT_UP_O,
	output logic COUNT_PULSE_OUTPUT_DOWN_O,
	output logic DIRECT_RELEASE_OUTPUT_A_O,
	output logic DIRECT_RELEASE_OUTPUT_B_O,
	// Section state
	output logic TRACK_TAKEN_OUTPUT_A_O,
	output logic TRACK_TAKEN_OUTPUT_B_O,
	output logic VACANCY_OUTPUT_A_O,
	output logic VACANCY_OUTPUT_B_O,
	output logic BREAKDOWN_INDICATOR_O,
	output logic IRQ_O
);
	import ace_pkg::*;

	localparam int unsigned NSYNC = 6;
	localparam int unsigned KW = $clog2(KEY_HOLD_CYCLES + 1);
	localparam int unsigned RW = $clog2(RELEASE_CYCLES + 1);

	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] sync_1;
	logic [NSYNC-1:0] sync_2;
	logic qual_one;
	logic qual_two;
	logic rej_one;
	logic rej_two;
	logic qual_one_d;
	logic qual_two_d;
	ace_fault_t fault_live;
	logic key_live;
	ace_dir_t dir_state;
	ace_dir_t next_dir;
	logic axle_in;
	logic axle_out;
	logic [CNT_W-1:0] cnt_a;
	logic [CNT_W-1:0] cnt_b;
	logic minus_lock;
	logic breakdown;
	logic mismatch;
	logic failsafe;
	logic taken;
	ace_seq_t seq_state;
	logic [KW-1:0] key_held;
	logic [RW-1:0] rel_timer;
	logic [1:0] entry_axles;
	logic [2:0] pulse_cnt;
	logic new_pulse;
	logic rel_trig;
	ace_cfg_t cfg;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_en;
	logic [IRQ_W-1:0] irq_evt;
	logic [31:0] rd_mux;
	logic bus_req;

	// -----------------------------------------------------------------
	// Pin synchronisers
	// -----------------------------------------------------------------
	assign pin_raw = {COUNTER_RESET_KEY_I, SENSOR_FAULT_I, SENSOR_SYSTEM_TWO_I,
		SENSOR_SYSTEM_ONE_I};

	// Two flops per pin; only the second stage is read by logic
	generate
		for (genvar i = 0; i < NSYNC; i++)
		begin : g_sync
			always_ff @(posedge REF_CLK_I)
			begin
				if (!RST_N_I)
				begin
					sync_1[i] <= 1'b0;
					sync_2[i] <= 1'b0;
				end
				else
				begin
					sync_1[i] <= pin_raw[i];
					sync_2[i] <= sync_1[i];
				end
			end
		end
	endgenerate

	assign fault_live = sync_2[4:2];
	assign key_live = sync_2[5];

	// -----------------------------------------------------------------
	// Pulse qualification, one per sensor system
	// -----------------------------------------------------------------
	ace_pulse_qualifier #(.MIN_CYC(MIN_PULSE_CYCLES)) u_qual_one (
		.clk_i(REF_CLK_I),
		.rst_n_i(RST_N_I),
		.level_i(sync_2[0]),
		.qual_o(qual_one),
		.reject_o(rej_one)
	);

	ace_pulse_qualifier #(.MIN_CYC(MIN_PULSE_CYCLES)) u_qual_two (
		.clk_i(REF_CLK_I),
		.rst_n_i(RST_N_I),
		.level_i(sync_2[1]),
		.qual_o(qual_two),
		.reject_o(rej_two)
	);

	// -----------------------------------------------------------------
	// Direction of travel: one then two is entering, two then one leaving
	// -----------------------------------------------------------------
	always_comb
	begin
		next_dir = dir_state;
		axle_in = 1'b0;
		axle_out = 1'b0;
		case (dir_state)
			DIR_IDLE: next_dir = (qual_one && !qual_two) ? DIR_A :
				(!qual_one && qual_two) ? DIR_B : DIR_IDLE;
			DIR_A: next_dir = (qual_one && qual_two) ? DIR_AB_A :
				(qual_one ? DIR_A : DIR_IDLE);
			DIR_AB_A: next_dir = (!qual_one && qual_two) ? DIR_B_A :
				(qual_one && !qual_two) ? DIR_A :
				(qual_one ? DIR_AB_A : DIR_IDLE);
			DIR_B_A:
			begin
				next_dir = (qual_one && qual_two) ? DIR_AB_A :
					(qual_two ? DIR_B_A : DIR_IDLE);
				axle_in = !qual_one && !qual_two;
			end
			DIR_B: next_dir = (qual_one && qual_two) ? DIR_AB_B :
				(qual_two ? DIR_B : DIR_IDLE);
			DIR_AB_B: next_dir = (qual_one && !qual_two) ? DIR_A_B :
				(!qual_one && qual_two) ? DIR_B :
				(qual_two ? DIR_AB_B : DIR_IDLE);
			DIR_A_B:
			begin
				next_dir = (qual_one && qual_two) ? DIR_AB_B :
					(qual_one ? DIR_A_B : DIR_IDLE);
				axle_out = !qual_one && !qual_two;
			end
			default: next_dir = DIR_IDLE;
		endcase
	end

	// Direction state and edge history for pulse counting
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
		begin
			dir_state <= DIR_IDLE;
			qual_one_d <= 1'b0;
			qual_two_d <= 1'b0;
		end
		else
		begin
			dir_state <= next_dir;
			qual_one_d <= qual_one;
			qual_two_d <= qual_two;
		end
	end

	// Momentary count pulses, suppressed while counting is blocked
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
		begin
			COUNT_PULSE_OUTPUT_UP_O <= 1'b0;
			COUNT_PULSE_OUTPUT_DOWN_O <= 1'b0;
		end
		else
		begin
			COUNT_PULSE_OUTPUT_UP_O <= axle_in && !failsafe;
			COUNT_PULSE_OUTPUT_DOWN_O <= axle_out && !failsafe;
		end
	end

	// -----------------------------------------------------------------
	// Occupation trigger and direct release timer
	// -----------------------------------------------------------------
	assign new_pulse = (qual_one && !qual_one_d) || (qual_two && !qual_two_d);
	// Trigger on the configured complete entering axle or pulse total
	// One bit wider so a saturated run counter cannot wrap past the threshold
	assign rel_trig = ((cfg.axle_thr != 2'h0) && axle_in &&
		(({1'b0, entry_axles} + 3'h1) >= {1'b0, cfg.axle_thr})) ||
		(cfg.pulse_en && new_pulse &&
		(({1'b0, pulse_cnt} + 4'h1) >= {1'b0, cfg.pulse_thr}));

	// Run counters restart once the section is clear, the sensor idle and the release timer expired
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
		begin
			entry_axles <= '0;
			pulse_cnt <= '0;
		end
		else if (taken || dir_state != DIR_IDLE || rel_timer != '0)
		begin
			if (axle_in && entry_axles != 2'h3)
				entry_axles <= entry_axles + 2'h1;
			if (new_pulse && pulse_cnt != 3'h7)
				pulse_cnt <= pulse_cnt + 3'h1;
		end
		else
		begin
			entry_axles <= '0;
			pulse_cnt <= {2'h0, new_pulse};
		end
	end

	// Extended release drives both redundant outputs regardless of count
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
		begin
			rel_timer <= '0;
			DIRECT_RELEASE_OUTPUT_A_O <= 1'b0;
			DIRECT_RELEASE_OUTPUT_B_O <= 1'b0;
		end
		else
		begin
			if (rel_trig)
				rel_timer <= RW'(RELEASE_CYCLES);
			else if (rel_timer != '0)
				rel_timer <= rel_timer - 1'b1;
			DIRECT_RELEASE_OUTPUT_A_O <= rel_trig || (rel_timer > RW'(1));
			DIRECT_RELEASE_OUTPUT_B_O <= rel_trig || (rel_timer > RW'(1));
		end
	end

	// -----------------------------------------------------------------
	// Dual counter channels
	// -----------------------------------------------------------------
	assign mismatch = (cnt_a != cnt_b);
	assign failsafe = minus_lock || breakdown;
	assign taken = failsafe || (cnt_a != '0) || (cnt_b != '0);

	// Both channels move together; sequence steps win over traffic
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
		begin
			cnt_a <= '0;
			cnt_b <= '0;
		end
		else if (seq_state == SEQ_CLEAR)
		begin
			cnt_a <= '0;
			cnt_b <= '0;
		end
		else if (seq_state == SEQ_IN)
		begin
			cnt_a <= cnt_a + 1'b1;
			cnt_b <= cnt_b + 1'b1;
		end
		else if (seq_state == SEQ_OUT)
		begin
			cnt_a <= cnt_a - 1'b1;
			cnt_b <= cnt_b - 1'b1;
		end
		else if (!failsafe)
		begin
			if (axle_in && cnt_a != '1 && cnt_b != '1)
			begin
				cnt_a <= cnt_a + 1'b1;
				cnt_b <= cnt_b + 1'b1;
			end
			else if (axle_out && cnt_a != '0 && cnt_b != '0)
			begin
				cnt_a <= cnt_a - 1'b1;
				cnt_b <= cnt_b - 1'b1;
			end
		end
	end

	// Minus-axle lockout; counting in cannot clear it, only the key sequence
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
			minus_lock <= 1'b0;
		else if (axle_out && !failsafe && (cnt_a == '0 || cnt_b == '0))
			minus_lock <= 1'b1;
		else if (seq_state == SEQ_CLEAR)
			minus_lock <= 1'b0;
	end

	// Breakdown latch: live sensor fault or channel divergence; set beats clear
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
			breakdown <= 1'b0;
		else if (fault_live != 3'h0)
			breakdown <= 1'b1;
		else if (mismatch && seq_state == SEQ_IDLE)
			breakdown <= 1'b1;
		else if (seq_state == SEQ_CLEAR)
			breakdown <= 1'b0;
	end

	// -----------------------------------------------------------------
	// Key reset sequence
	// -----------------------------------------------------------------
	// Key must stay held the full time; a sensor fault still present refuses it
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
		begin
			key_held <= '0;
			seq_state <= SEQ_IDLE;
		end
		else
		begin
			if (!key_live)
				key_held <= '0;
			else if (key_held != KW'(KEY_HOLD_CYCLES))
				key_held <= key_held + 1'b1;
			case (seq_state)
				SEQ_IDLE:
					if (key_held == KW'(KEY_HOLD_CYCLES) && fault_live == 3'h0)
						seq_state <= SEQ_CLEAR;
				SEQ_CLEAR: seq_state <= SEQ_IN;
				SEQ_IN: seq_state <= SEQ_OUT;
				SEQ_OUT: seq_state <= SEQ_WAIT;
				// One sequence per actuation: wait for the key to drop
				SEQ_WAIT:
					if (!key_live)
						seq_state <= SEQ_IDLE;
				default: seq_state <= SEQ_IDLE;
			endcase
		end
	end

	// -----------------------------------------------------------------
	// Section outputs
	// -----------------------------------------------------------------
	// Any fail-safe latch forces occupied, never vacant
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
		begin
			TRACK_TAKEN_OUTPUT_A_O <= 1'b1;
			TRACK_TAKEN_OUTPUT_B_O <= 1'b1;
			VACANCY_OUTPUT_A_O <= 1'b0;
			VACANCY_OUTPUT_B_O <= 1'b0;
			BREAKDOWN_INDICATOR_O <= 1'b0;
		end
		else
		begin
			TRACK_TAKEN_OUTPUT_A_O <= taken;
			TRACK_TAKEN_OUTPUT_B_O <= taken;
			VACANCY_OUTPUT_A_O <= !taken && seq_state == SEQ_IDLE;
			VACANCY_OUTPUT_B_O <= !taken && seq_state == SEQ_IDLE;
			BREAKDOWN_INDICATOR_O <= breakdown;
		end
	end

	// -----------------------------------------------------------------
	// Interrupts: sticky status, write-one clear, enable mask
	// -----------------------------------------------------------------
	assign irq_evt = {rej_one || rej_two, seq_state == SEQ_OUT,
		breakdown == 1'b0 && (fault_live != 3'h0 || mismatch),
		axle_out && !failsafe && (cnt_a == '0 || cnt_b == '0),
		COUNT_PULSE_OUTPUT_DOWN_O, COUNT_PULSE_OUTPUT_UP_O};

	// A new event in the clearing cycle stays set
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
		begin
			irq_stat <= '0;
			IRQ_O <= 1'b0;
		end
		else
		begin
			if (bus_req && AVS_WRITE_I && AVS_ADDRESS_I == REG_IRQ_CLEAR && AVS_BYTEENABLE_I[0])
				irq_stat <= (irq_stat & ~AVS_WRITEDATA_I[IRQ_W-1:0]) | irq_evt;
			else
				irq_stat <= irq_stat | irq_evt;
			IRQ_O <= ((irq_stat | irq_evt) & irq_en) != '0;
		end
	end

	// -----------------------------------------------------------------
	// Avalon-MM slave: one wait cycle, then waitrequest low for one cycle
	// -----------------------------------------------------------------
	assign bus_req = (AVS_READ_I || AVS_WRITE_I) && !AVS_WAITREQUEST_O;

	// Read multiplexer; unmapped and write-only words read zero
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		case (AVS_ADDRESS_I)
			REG_CTRL: rd_mux[5:0] = cfg;
			REG_STATUS:
			begin
				rd_mux[ST_CNT_A +: CNT_W] = cnt_a;
				rd_mux[ST_CNT_B +: CNT_W] = cnt_b;
				rd_mux[ST_MINUS] = minus_lock;
				rd_mux[ST_BREAKDOWN] = breakdown;
				rd_mux[ST_TAKEN] = taken;
				rd_mux[ST_RESET_BUSY] = seq_state != SEQ_IDLE;
				rd_mux[ST_FAULT +: 3] = fault_live;
			end
			REG_IRQ_STATUS: rd_mux[IRQ_W-1:0] = irq_stat;
			REG_IRQ_ENABLE: rd_mux[IRQ_W-1:0] = irq_en;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Handshake, read data capture and writable registers
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RST_N_I)
		begin
			AVS_WAITREQUEST_O <= 1'b1;
			AVS_READDATA_O <= 32'h0000_0000;
			cfg <= CFG_RST;
			irq_en <= '0;
		end
		else
		begin
			AVS_WAITREQUEST_O <= !((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O);
			if ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O)
				AVS_READDATA_O <= AVS_READ_I ? rd_mux : 32'h0000_0000;
			if (bus_req && AVS_WRITE_I && AVS_BYTEENABLE_I[0])
			begin
				if (AVS_ADDRESS_I == REG_CTRL)
					cfg <= AVS_WRITEDATA_I[5:0];
				if (AVS_ADDRESS_I == REG_IRQ_ENABLE)
					irq_en <= AVS_WRITEDATA_I[IRQ_W-1:0];
			end
		end
	end
endmodule // ace_axle_count_evaluator

// >>> include/ace_pkg.sv
// Shared constants and types for the axle count evaluator.
// Assumes a single 40 MHz clock and a word-addressed Avalon-MM slave port.
package ace_pkg;
	// -----------------------------------------------------------------
	// Timing
	// -----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned CLK_KHZ = CLK_HZ / 1000;
	localparam int unsigned MIN_PULSE_US = 500;
	localparam int unsigned MIN_PULSE_CYC = (CLK_KHZ * MIN_PULSE_US + 999) / 1000;
	localparam int unsigned KEY_HOLD_MS = 2000;
	localparam int unsigned KEY_HOLD_CYC = CLK_KHZ * KEY_HOLD_MS;
	localparam int unsigned RELEASE_MS = 100;
	localparam int unsigned RELEASE_CYC = CLK_KHZ * RELEASE_MS;
	localparam int unsigned CNT_W = 8;

	// -----------------------------------------------------------------
	// Register word offsets (byte address = 4 * offset)
	// -----------------------------------------------------------------
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_STATUS = 3'h1;
	localparam logic [2:0] REG_IRQ_STATUS = 3'h2;
	localparam logic [2:0] REG_IRQ_CLEAR = 3'h3;
	localparam logic [2:0] REG_IRQ_ENABLE = 3'h4;

	// Interrupt bit positions
	localparam int unsigned IRQ_W = 6;
	localparam int unsigned IRQ_AXLE_IN = 0;
	localparam int unsigned IRQ_AXLE_OUT = 1;
	localparam int unsigned IRQ_MINUS = 2;
	localparam int unsigned IRQ_BREAKDOWN = 3;
	localparam int unsigned IRQ_RESET_DONE = 4;
	localparam int unsigned IRQ_NOISE = 5;

	// Status field positions
	localparam int unsigned ST_CNT_A = 0;
	localparam int unsigned ST_CNT_B = 8;
	localparam int unsigned ST_MINUS = 16;
	localparam int unsigned ST_BREAKDOWN = 17;
	localparam int unsigned ST_TAKEN = 18;
	localparam int unsigned ST_RESET_BUSY = 19;
	localparam int unsigned ST_FAULT = 20;

	// -----------------------------------------------------------------
	// Carriers
	// -----------------------------------------------------------------
	typedef struct packed {
		logic off_rail;
		logic cable_open;
		logic cable_short;
	} ace_fault_t;

	typedef struct packed {
		logic [2:0] pulse_thr;
		logic pulse_en;
		logic [1:0] axle_thr;
	} ace_cfg_t;

	localparam ace_cfg_t CFG_RST = '{pulse_thr: 3'h3, pulse_en: 1'b1, axle_thr: 2'h1};

	typedef enum logic [6:0] {
		DIR_IDLE = 7'h01,
		DIR_A = 7'h02,
		DIR_AB_A = 7'h04,
		DIR_B_A = 7'h08,
		DIR_B = 7'h10,
		DIR_AB_B = 7'h20,
		DIR_A_B = 7'h40
	} ace_dir_t;

	typedef enum logic [4:0] {
		SEQ_IDLE = 5'h01,
		SEQ_CLEAR = 5'h02,
		SEQ_IN = 5'h04,
		SEQ_OUT = 5'h08,
		SEQ_WAIT = 5'h10
	} ace_seq_t;
endpackage

// >>> verilog/ace_pulse_qualifier.sv
// Minimum-duration qualifier for one wheel sensor system.
// Assumes its input is already synchronised to the clock.
module ace_pulse_qualifier #(
	parameter int unsigned MIN_CYC = 20000
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Raw level in
	input wire logic level_i,
	// Qualified level and rejected-pulse strobe out
	output logic qual_o,
	output logic reject_o
);
	localparam int unsigned CW = $clog2(MIN_CYC + 1);
	localparam logic [CW-1:0] LIMIT = CW'(MIN_CYC - 1);

	logic [CW-1:0] held;

	// -----------------------------------------------------------------
	// Duration count; short pulses never reach the output
	// -----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			held <= '0;
			qual_o <= 1'b0;
			reject_o <= 1'b0;
		end
		else
		begin
			reject_o <= 1'b0;
			if (!level_i)
			begin
				// A pulse that ended before qualifying is noise
				reject_o <= (held != '0) && !qual_o;
				held <= '0;
				qual_o <= 1'b0;
			end
			else if (held >= LIMIT)
			begin
				qual_o <= 1'b1;
			end
			else
			begin
				held <= held + 1'b1;
			end
		end
	end
endmodule // ace_pulse_qualifier

// >>> tb/ace_sensor_model.sv
// Behavioural double wheel sensor: two occupancy levels and fault lines.
// Assumes the bench calls its tasks right after a rising clock edge.
module ace_sensor_model
	import ace_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Sensor levels and fault lines
	output logic one_o,
	output logic two_o,
	output ace_fault_t fault_o
);
	// Idle sensor, healthy lines
	initial
	begin
		one_o = 1'b0;
		two_o = 1'b0;
		fault_o = '0;
	end

	// Hold one level pair for n cycles
	task automatic phase(input logic a, input logic b, input int n);
		one_o <= a;
		two_o <= b;
		repeat (n) @(posedge clk_i);
	endtask

	// Full flange crossing; entering crosses system one first
	task automatic axle(input logic leave, input int n);
		phase(!leave, leave, n);
		phase(1'b1, 1'b1, n);
		phase(leave, !leave, n);
		phase(1'b0, 1'b0, n);
	endtask

	// Short disturbance on system one only
	task automatic glitch(input int n);
		phase(1'b1, 1'b0, n);
		phase(1'b0, 1'b0, 12);
	endtask

	// Live fault levels held until changed
	task automatic fault(input ace_fault_t f);
		fault_o <= f;
	endtask
endmodule // ace_sensor_model

// >>> tb/ace_axle_count_evaluator_monitor.sv
// Port-level checker for the axle count evaluator.
// Assumes one clock domain and the synchronous active-low reset.
module ace_axle_count_evaluator_monitor
	import ace_pkg::*;
#(
	parameter int unsigned RELEASE_CYCLES = 20
) (
	input wire logic REF_CLK_I,
	input wire logic RST_N_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic AVS_WAITREQUEST_O,
	input wire ace_pkg::ace_fault_t SENSOR_FAULT_I,
	input wire logic COUNT_PULSE_OUTPUT_UP_O,
	input wire logic COUNT_PULSE_OUTPUT_DOWN_O,
	input wire logic DIRECT_RELEASE_OUTPUT_A_O,
	input wire logic DIRECT_RELEASE_OUTPUT_B_O,
	input wire logic TRACK_TAKEN_OUTPUT_A_O,
	input wire logic TRACK_TAKEN_OUTPUT_B_O,
	input wire logic VACANCY_OUTPUT_A_O,
	input wire logic VACANCY_OUTPUT_B_O,
	input wire logic BREAKDOWN_INDICATOR_O
);
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!RST_N_I);
	logic [31:0] rel_cnt;

	// Length of the current release pulse
	always_ff @(posedge REF_CLK_I)
		rel_cnt <= (!RST_N_I || !DIRECT_RELEASE_OUTPUT_A_O) ? 32'h0 : rel_cnt + 32'h1;

	property p_taken_pair;
		TRACK_TAKEN_OUTPUT_A_O == TRACK_TAKEN_OUTPUT_B_O && VACANCY_OUTPUT_A_O == VACANCY_OUTPUT_B_O;
	endproperty
	a_taken_pair: assert property (p_taken_pair) else $error("section outputs differ");
	property p_vac_excl;
		VACANCY_OUTPUT_A_O |-> !TRACK_TAKEN_OUTPUT_A_O && !BREAKDOWN_INDICATOR_O;
	endproperty
	a_vac_excl: assert property (p_vac_excl) else $error("vacant while taken");
	property p_up_taken;
		COUNT_PULSE_OUTPUT_UP_O |-> ##[0:2] (TRACK_TAKEN_OUTPUT_A_O && !VACANCY_OUTPUT_A_O);
	endproperty
	a_up_taken: assert property (p_up_taken) else $error("axle in left section vacant");
	property p_fault_fs;
		SENSOR_FAULT_I != '0 |-> ##[1:4] (BREAKDOWN_INDICATOR_O && TRACK_TAKEN_OUTPUT_A_O);
	endproperty
	a_fault_fs: assert property (p_fault_fs) else $error("fault without fail-safe");
	property p_bkn_quiet;
		BREAKDOWN_INDICATOR_O && $past(BREAKDOWN_INDICATOR_O)
			|-> !COUNT_PULSE_OUTPUT_UP_O && !COUNT_PULSE_OUTPUT_DOWN_O;
	endproperty
	a_bkn_quiet: assert property (p_bkn_quiet) else $error("counting in breakdown");
	property p_rel_pair;
		DIRECT_RELEASE_OUTPUT_A_O == DIRECT_RELEASE_OUTPUT_B_O;
	endproperty
	a_rel_pair: assert property (p_rel_pair) else $error("release outputs differ");
	property p_rel_len;
		$fell(DIRECT_RELEASE_OUTPUT_A_O) |-> rel_cnt >= RELEASE_CYCLES;
	endproperty
	a_rel_len: assert property (p_rel_len) else $error("release pulse too short");
	property p_wait_one;
		(AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("bus answer late");
	property p_wait_idle;
		!AVS_READ_I && !AVS_WRITE_I |=> AVS_WAITREQUEST_O;
	endproperty
	a_wait_idle: assert property (p_wait_idle) else $error("bus answer without request");
endmodule // ace_axle_count_evaluator_monitor

bind ace_axle_count_evaluator ace_axle_count_evaluator_monitor #(
	.RELEASE_CYCLES(RELEASE_CYCLES)
) mon_i (.REF_CLK_I, .RST_N_I, .AVS_READ_I, .AVS_WRITE_I, .AVS_WAITREQUEST_O,
	.SENSOR_FAULT_I, .COUNT_PULSE_OUTPUT_UP_O, .COUNT_PULSE_OUTPUT_DOWN_O,
	.DIRECT_RELEASE_OUTPUT_A_O, .DIRECT_RELEASE_OUTPUT_B_O, .TRACK_TAKEN_OUTPUT_A_O,
	.TRACK_TAKEN_OUTPUT_B_O, .VACANCY_OUTPUT_A_O, .VACANCY_OUTPUT_B_O, .BREAKDOWN_INDICATOR_O);

// >>> tb/tb.sv
// Self-checking bench for the axle count evaluator with short timing parameters.
// Assumes the sensor model and the monitor are compiled before it.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ace_pkg::*;
	`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
		$display("wrong value %s expected %h seen %h", n, e, g); end end
	localparam int KH = 50;
	logic clk, rst_n, rd, wr, key, leave, rel_seen;
	logic [2:0] adr;
	logic [31:0] wd, q, rdata, seed, r;
	logic wreq, up, dn, rel_a, rel_b, tk_a, tk_b, vac_a, vac_b, breakdown_indicator, irq, s1, s2;
	ace_fault_t flt;
	logic [3:0] be = 4'hf;
	int fails, checks_done, ups, dns, ups_e, dns_e, cnt;

	ace_axle_count_evaluator #(.MIN_PULSE_CYCLES(8), .KEY_HOLD_CYCLES(KH), .RELEASE_CYCLES(20))
	ace_axle_count_evaluator_i (.REF_CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr),
		.AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be),
		.AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq), .SENSOR_SYSTEM_ONE_I(s1),
		.SENSOR_SYSTEM_TWO_I(s2), .SENSOR_FAULT_I(flt), .COUNTER_RESET_KEY_I(key),
		.COUNT_PULSE_OUTPUT_UP_O(up), .COUNT_PULSE_OUTPUT_DOWN_O(dn),
		.DIRECT_RELEASE_OUTPUT_A_O(rel_a), .DIRECT_RELEASE_OUTPUT_B_O(rel_b),
		.TRACK_TAKEN_OUTPUT_A_O(tk_a), .TRACK_TAKEN_OUTPUT_B_O(tk_b),
		.VACANCY_OUTPUT_A_O(vac_a), .VACANCY_OUTPUT_B_O(vac_b),
		.BREAKDOWN_INDICATOR_O(breakdown_indicator), .IRQ_O(irq));
	ace_sensor_model ace_sensor_model_i (.clk_i(clk), .one_o(s1), .two_o(s2), .fault_o(flt));

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Status word expected from count, lock, breakdown and live faults
	function automatic logic [22:0] exp_st(input int c, input logic m, input logic b,
		input logic [2:0] f);
		return {f, 1'b0, (c != 0) || m || b, b, m, 8'(c), 8'(c)};
	endfunction

	// One Avalon transfer; request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk);
		while (wreq !== 1'b0)
			@(posedge clk);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		// Idle edge: the next call never drives the strobes twice in one step
		@(posedge clk);
	endtask

	task automatic chk_st(input int c, input logic m, input logic b, input logic [2:0] f);
		bus(1'b0, REG_STATUS, 32'h0);
		`CHK("status", exp_st(c, m, b, f), q[22:0])
	endtask

	// Key held well past the hold time, then released; the bench keeps the hold rule
	task automatic key_seq();
		key <= 1'b1;
		repeat (KH + 30) @(posedge clk);
		key <= 1'b0;
		repeat (10) @(posedge clk);
	endtask

	task automatic stop_test();
		if (fails == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Clock, observers, watchdog
	// ---------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Count pulses and release activity as seen at the pins
	always @(posedge clk)
	begin
		if (up === 1'b1) ups++;
		if (dn === 1'b1) dns++;
		if (rel_a === 1'b1) rel_seen = 1'b1;
	end

	// Whole run is a few thousand cycles
	initial
	begin
		repeat (30000) @(posedge clk);
		fails++;
		stop_test();
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial
	begin
		{rst_n, rd, wr, key, adr, wd, rel_seen} = '0;
		seed = 32'd92034;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		bus(1'b0, REG_CTRL, 32'h0);
		`CHK("ctrl reset", 32'h1d, q)
		// Random settings, then a write with lane 0 off must be ignored
		r = xs();
		bus(1'b1, REG_CTRL, r);
		bus(1'b0, REG_CTRL, 32'h0);
		`CHK("ctrl", {26'h0, r[5:0]}, q)
		be <= 4'he;
		bus(1'b1, REG_CTRL, 32'h1d);
		bus(1'b0, REG_CTRL, 32'h0);
		`CHK("ctrl lane", {26'h0, r[5:0]}, q)
		be <= 4'hf;
		bus(1'b1, REG_CTRL, 32'h1d);
		bus(1'b1, 3'h6, 32'hff);
		bus(1'b0, 3'h6, 32'h0);
		`CHK("unmapped", 32'h0, q)
		bus(1'b1, REG_IRQ_ENABLE, 32'h3f);
		ace_sensor_model_i.glitch(3);
		chk_st(0, 1'b0, 1'b0, 3'h0);
		`CHK("release after noise", 1'b0, rel_seen)
		bus(1'b0, REG_IRQ_STATUS, 32'h0);
		`CHK("noise event", 32'h20, q)
		`CHK("irq raised", 1'b1, irq)
		bus(1'b1, REG_IRQ_CLEAR, 32'h20);
		repeat (2) @(posedge clk);
		`CHK("irq cleared", 1'b0, irq)
		// Random traffic, never leaving an empty section
		for (int i = 0; i < 10; i++)
		begin
			r = xs();
			leave = cnt > 0 && r[0];
			ace_sensor_model_i.axle(leave, 10 + int'(r[4:1]));
			cnt += leave ? -1 : 1;
			if (leave) dns_e++; else ups_e++;
			chk_st(cnt, 1'b0, 1'b0, 3'h0);
			`CHK("up pulses", ups_e, ups)
			`CHK("down pulses", dns_e, dns)
			`CHK("vacancy", cnt == 0, vac_a)
		end
		`CHK("direct release", 1'b1, rel_seen)
		while (cnt > 0)
		begin
			ace_sensor_model_i.axle(1'b1, 12);
			cnt--;
		end
		chk_st(0, 1'b0, 1'b0, 3'h0);
		`CHK("vacant again", 1'b1, vac_a)
		// Minus axle, then an attempt to balance it
		ace_sensor_model_i.axle(1'b1, 12);
		chk_st(0, 1'b1, 1'b0, 3'h0);
		ace_sensor_model_i.axle(1'b0, 12);
		chk_st(0, 1'b1, 1'b0, 3'h0);
		`CHK("held taken", 1'b1, tk_b)
		bus(1'b0, REG_IRQ_STATUS, 32'h0);
		`CHK("minus event", 1'b1, q[IRQ_MINUS])
		bus(1'b1, REG_IRQ_ENABLE, 32'h0);
		repeat (2) @(posedge clk);
		`CHK("irq masked", 1'b0, irq)
		key_seq();
		chk_st(0, 1'b0, 1'b0, 3'h0);
		`CHK("standby", 1'b1, vac_b)
		// Each sensor fault; key refused while it lasts
		for (int i = 0; i < 3; i++)
		begin
			ace_sensor_model_i.fault(ace_fault_t'(3'(1 << i)));
			repeat (6) @(posedge clk);
			chk_st(0, 1'b0, 1'b1, 3'(1 << i));
			key_seq();
			chk_st(0, 1'b0, 1'b1, 3'(1 << i));
			ace_sensor_model_i.fault(ace_fault_t'(3'h0));
			key_seq();
			chk_st(0, 1'b0, 1'b0, 3'h0);
			`CHK("restored", 1'b1, vac_a)
		end
		stop_test();
	end
endmodule // tb
